/* File: hw/data_eeprom_write_guard.sv */
`timescale 1ns/100ps
// Functional notes
// - With data code protection on, refuse every external read and write.
// - Start on protected or invalid address clears start, memory unchanged.
// - Such a rejected start sets the program fault flag.
// - Reset clears the program permit bit.
// - No write may start while the power-up timer runs.
// - CPU write starts only with permit set and unlock completed; external writes need neither.
module data_eeprom_write_guard
    import eeprom_guard_pkg::*;
#(
    parameter int PWRT_CYCLES_P = PWRT_CYCLES,
    parameter int WRITE_CYCLES_P = WRITE_CYCLES
)
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CODE_PROTECT,
    input wire logic WRITE_PROTECT,
    input wire logic EXT_REQ,
    input wire logic EXT_WRITE,
    input wire logic [7:0] EXT_ADDR,
    input wire logic [7:0] EXT_WDATA,
    output logic [7:0] EXT_RDATA,
    output logic EXT_ACK,
    output logic EXT_REFUSED,
    output logic IRQ
);
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic permit_q, permit_d;
    logic start_q, start_d;
    logic fault_q, fault_d;
    logic [1:0] region_q, region_d;
    unlock_e ulk_q, ulk_d;
    logic [7:0] addr_lo_q, addr_lo_d;
    logic [7:0] addr_hi_q, addr_hi_d;
    logic [7:0] data_q, data_d;
    logic [1:0] irq_st_q, irq_st_d;
    logic [1:0] irq_mask_q, irq_mask_d;
    logic irq_q, irq_d;
    logic [31:0] pwrt_cnt_q, pwrt_cnt_d;
    logic pwrt_done_q, pwrt_done_d;
    logic [7:0] ext_rdata_q, ext_rdata_d;
    logic ext_ack_q, ext_ack_d;
    logic ext_refused_q, ext_refused_d;
    logic bus_wr, setup, hit, invalid, req_start, req_fetch;
    logic cpu_start, ext_start, mem_start, mem_busy, mem_done;
    logic [7:0] mem_rd_a, mem_rd_b;

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign EXT_RDATA = ext_rdata_q;
    assign EXT_ACK = ext_ack_q;
    assign EXT_REFUSED = ext_refused_q;
    assign IRQ = irq_q;

    assign setup = PSEL & ~PENABLE;
    assign bus_wr = PSEL & PENABLE & PWRITE & pready_q & ~pslverr_q;
    assign hit = (PADDR == OFS_CONTROL) || (PADDR == OFS_UNLOCK) ||
        (PADDR == OFS_ADDR_LOW) || (PADDR == OFS_ADDR_HIGH) ||
        (PADDR == OFS_DATA) || (PADDR == OFS_IRQ_STATUS) ||
        (PADDR == OFS_IRQ_MASK) || (PADDR == OFS_STATE);
    // Only the data region with an in-range pointer can be programmed
    assign invalid = (addr_hi_q != 8'h00) || (region_q != 2'b00);
    assign mem_start = cpu_start | ext_start;

    eeprom_cell_array #(
        .WRITE_CYCLES_P(WRITE_CYCLES_P)
    ) u_cells (
        .clk(CLOCK),
        .rst(RST),
        .start(mem_start),
        .wr_addr(cpu_start ? addr_lo_q : EXT_ADDR),
        .wr_data(cpu_start ? data_q : EXT_WDATA),
        .rd_addr_a(addr_lo_q),
        .rd_addr_b(EXT_ADDR),
        .rd_data_a(mem_rd_a),
        .rd_data_b(mem_rd_b),
        .busy(mem_busy),
        .done(mem_done)
    );

    always_comb
    begin
        prdata_d = prdata_q;
        pready_d = setup;
        pslverr_d = setup & ~hit;
        permit_d = permit_q;
        start_d = start_q;
        fault_d = fault_q;
        region_d = region_q;
        ulk_d = ulk_q;
        addr_lo_d = addr_lo_q;
        addr_hi_d = addr_hi_q;
        data_d = data_q;
        irq_st_d = irq_st_q;
        irq_mask_d = irq_mask_q;
        pwrt_cnt_d = pwrt_cnt_q;
        pwrt_done_d = pwrt_done_q;
        ext_rdata_d = ext_rdata_q;
        ext_ack_d = EXT_REQ;
        ext_refused_d = 1'b0;
        req_start = 1'b0;
        req_fetch = 1'b0;
        cpu_start = 1'b0;
        ext_start = 1'b0;

        if (!pwrt_done_q)
        begin
            if (pwrt_cnt_q == 32'(PWRT_CYCLES_P - 1))
                pwrt_done_d = 1'b1;
            else
                pwrt_cnt_d = pwrt_cnt_q + 32'd1;
        end

        // Read data prepared in setup so PRDATA can come from a flop
        if (setup)
        begin
            prdata_d = 32'h0;
            unique case (PADDR)
                OFS_CONTROL:
                begin
                    prdata_d[CTL_START] = start_q;
                    prdata_d[CTL_PERMIT] = permit_q;
                    prdata_d[CTL_FAULT] = fault_q;
                    prdata_d[CTL_REGION_LSB +: 2] = region_q;
                end
                OFS_ADDR_LOW: prdata_d[7:0] = addr_lo_q;
                OFS_ADDR_HIGH: prdata_d[7:0] = addr_hi_q;
                OFS_DATA: prdata_d[7:0] = data_q;
                OFS_IRQ_STATUS: prdata_d[1:0] = irq_st_q;
                OFS_IRQ_MASK: prdata_d[1:0] = irq_mask_q;
                OFS_STATE:
                begin
                    prdata_d[ST_BUSY] = mem_busy;
                    prdata_d[ST_PWRT_DONE] = pwrt_done_q;
                    prdata_d[ST_ARMED] = (ulk_q == ULK_ARMED);
                end
                default: prdata_d = 32'h0;
            endcase
        end

        if (bus_wr)
        begin
            unique case (PADDR)
                OFS_CONTROL:
                begin
                    permit_d = PWDATA[CTL_PERMIT];
                    region_d = PWDATA[CTL_REGION_LSB +: 2];
                    // Fault clears only when written as zero
                    fault_d = fault_q & PWDATA[CTL_FAULT];
                    req_start = PWDATA[CTL_START] & ~start_q;
                    req_fetch = PWDATA[CTL_FETCH];
                end
                OFS_UNLOCK:
                begin
                    // Any wrong byte drops the sequence back to the start
                    if (ulk_q == ULK_IDLE && PWDATA[7:0] == UNLOCK_KEY1)
                        ulk_d = ULK_HALF;
                    else if (ulk_q == ULK_HALF &&
                             PWDATA[7:0] == UNLOCK_KEY2)
                        ulk_d = ULK_ARMED;
                    else
                        ulk_d = ULK_IDLE;
                end
                OFS_ADDR_LOW: addr_lo_d = PWDATA[7:0];
                OFS_ADDR_HIGH: addr_hi_d = PWDATA[7:0];
                OFS_DATA: data_d = PWDATA[7:0];
                OFS_IRQ_STATUS: irq_st_d = irq_st_q & ~PWDATA[1:0];
                OFS_IRQ_MASK: irq_mask_d = PWDATA[1:0];
                default: ;
            endcase
        end

        // Fetch is a pulse; the bit never reads back as set
        if (req_fetch && region_d == 2'b00)
            data_d = (addr_hi_q == 8'h00) ? mem_rd_a : 8'h00;

        if (req_start)
        begin
            // A start attempt always uses up the unlock
            ulk_d = ULK_IDLE;
            if (permit_d && ulk_q == ULK_ARMED && pwrt_done_q &&
                !mem_busy)
            begin
                if (WRITE_PROTECT || invalid)
                begin
                    fault_d = 1'b1;
                    irq_st_d[IRQ_FAULT] = 1'b1;
                end
                else
                begin
                    start_d = 1'b1;
                    cpu_start = 1'b1;
                end
            end
        end

        if (mem_done && start_q)
        begin
            start_d = 1'b0;
            irq_st_d[IRQ_DONE] = 1'b1;
        end

        if (EXT_REQ)
        begin
            if (CODE_PROTECT)
                ext_refused_d = 1'b1;
            else if (EXT_WRITE)
            begin
                // The cell array has one program engine
                if (mem_busy || cpu_start || !pwrt_done_q)
                    ext_refused_d = 1'b1;
                else
                    ext_start = 1'b1;
            end
            else
                ext_rdata_d = mem_rd_b;
        end

        irq_d = |(irq_st_d & irq_mask_d);
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            prdata_q <= PRDATA_RESET;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            permit_q <= 1'b0;
            start_q <= 1'b0;
            fault_q <= 1'b0;
            region_q <= 2'b00;
            ulk_q <= ULK_IDLE;
            addr_lo_q <= 8'h00;
            addr_hi_q <= 8'h00;
            data_q <= 8'h00;
            irq_st_q <= 2'h0;
            irq_mask_q <= IRQ_MASK_RESET;
            irq_q <= 1'b0;
            pwrt_cnt_q <= 32'h0;
            pwrt_done_q <= 1'b0;
            ext_rdata_q <= 8'h00;
            ext_ack_q <= 1'b0;
            ext_refused_q <= 1'b0;
        end
        else
        begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            permit_q <= permit_d;
            start_q <= start_d;
            fault_q <= fault_d;
            region_q <= region_d;
            ulk_q <= ulk_d;
            addr_lo_q <= addr_lo_d;
            addr_hi_q <= addr_hi_d;
            data_q <= data_d;
            irq_st_q <= irq_st_d;
            irq_mask_q <= irq_mask_d;
            irq_q <= irq_d;
            pwrt_cnt_q <= pwrt_cnt_d;
            pwrt_done_q <= pwrt_done_d;
            ext_rdata_q <= ext_rdata_d;
            ext_ack_q <= ext_ack_d;
            ext_refused_q <= ext_refused_d;
        end
    end
endmodule

/* File: hw/eeprom_guard_pkg.sv */
package eeprom_guard_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int PWRT_TIME_NS = 64_000_000;
    localparam int PWRT_CYCLES = PWRT_TIME_NS / CLK_PERIOD_NS;
    localparam int WRITE_TIME_NS = 4_000_000;
    localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int MEM_DEPTH = 256;
    localparam int ADDR_W = 8;

    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_UNLOCK = 8'h04;
    localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h0c;
    localparam logic [7:0] OFS_DATA = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFS_STATE = 8'h1c;

    localparam int CTL_FETCH = 0;
    localparam int CTL_START = 1;
    localparam int CTL_PERMIT = 2;
    localparam int CTL_FAULT = 3;
    localparam int CTL_REGION_LSB = 6;

    localparam int IRQ_DONE = 0;
    localparam int IRQ_FAULT = 1;

    localparam int ST_BUSY = 0;
    localparam int ST_PWRT_DONE = 1;
    localparam int ST_ARMED = 2;

    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;

    localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    typedef enum logic [2:0] {
        ULK_IDLE = 3'b001,
        ULK_HALF = 3'b010,
        ULK_ARMED = 3'b100
    } unlock_e;
endpackage

/* File: hw/eeprom_cell_array.sv */
`timescale 1ns/100ps
module eeprom_cell_array
    import eeprom_guard_pkg::*;
#(
    parameter int WRITE_CYCLES_P = WRITE_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [ADDR_W-1:0] rd_addr_a,
    input wire logic [ADDR_W-1:0] rd_addr_b,
    output logic [7:0] rd_data_a,
    output logic [7:0] rd_data_b,
    output logic busy,
    output logic done
);
    logic [7:0] mem [MEM_DEPTH];
    logic [31:0] cnt_q, cnt_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [7:0] data_q, data_d;
    logic commit;

    assign rd_data_a = mem[rd_addr_a];
    assign rd_data_b = mem[rd_addr_b];
    assign busy = busy_q;
    assign done = done_q;

    always_comb
    begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        addr_d = addr_q;
        data_d = data_q;
        done_d = 1'b0;
        commit = 1'b0;
        if (busy_q)
        begin
            // Cell content changes only when the program time has elapsed
            if (cnt_q == 32'(WRITE_CYCLES_P - 1))
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
                commit = 1'b1;
            end
            else
                cnt_d = cnt_q + 32'd1;
        end
        else if (start)
        begin
            busy_d = 1'b1;
            cnt_d = 32'd0;
            addr_d = wr_addr;
            data_d = wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 32'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            addr_q <= '0;
            data_q <= 8'h00;
        end
        else
        begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
            addr_q <= addr_d;
            data_q <= data_d;
        end
    end

    // Nonvolatile: contents survive reset
    always_ff @(posedge clk)
    begin
        if (commit)
            mem[addr_q] <= data_q;
    end
endmodule

/* File: tb/data_eeprom_write_guard_asserts.sv */
`timescale 1ns/100ps
module data_eeprom_write_guard_asserts
    import eeprom_guard_pkg::*;
#(
    parameter int PWRT_CYCLES_P = PWRT_CYCLES
)
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic CODE_PROTECT,
    input wire logic EXT_REQ,
    input wire logic EXT_WRITE,
    input wire logic [7:0] EXT_RDATA,
    input wire logic EXT_ACK,
    input wire logic EXT_REFUSED
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    // Cycles since release, saturating so long runs cannot wrap
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    always_comb cnt_d = (cnt_q < 32'h0000ffff) ? cnt_q + 32'h1 : cnt_q;
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST) cnt_q <= 32'h0;
        else cnt_q <= cnt_d;
    end
    property p_cp_refuse;
        EXT_REQ && CODE_PROTECT |=> EXT_ACK && EXT_REFUSED;
    endproperty
    a_cp_refuse: assert property (p_cp_refuse)
        else $error("external request not refused under code protection");
    property p_ext_ack;
        EXT_REQ |=> EXT_ACK;
    endproperty
    a_ext_ack: assert property (p_ext_ack)
        else $error("external request not acknowledged");
    property p_ack_cause;
        EXT_ACK |-> $past(EXT_REQ);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("acknowledge without request");
    property p_rdata;
        $changed(EXT_RDATA) |-> EXT_ACK && !EXT_REFUSED;
    endproperty
    a_rdata: assert property (p_rdata)
        else $error("external read data changed without accepted read");
    property p_pwrt;
        EXT_REQ && EXT_WRITE && cnt_q < 32'(PWRT_CYCLES_P) |=> EXT_REFUSED;
    endproperty
    a_pwrt: assert property (p_pwrt)
        else $error("write accepted while power-up timer runs");
    property p_ready;
        PSEL && !PENABLE |=> PREADY;
    endproperty
    a_ready: assert property (p_ready)
        else $error("no ready in first access cycle");
    property p_ready_pulse;
        PREADY |=> !PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready longer than one cycle");
    property p_err;
        PSLVERR |-> PREADY;
    endproperty
    a_err: assert property (p_err)
        else $error("slave error without ready");
    c_refused: cover property (EXT_ACK && EXT_REFUSED);
    c_accepted: cover property (EXT_ACK && !EXT_REFUSED);
    c_slverr: cover property (PSLVERR);
endmodule
bind data_eeprom_write_guard data_eeprom_write_guard_asserts
    #(.PWRT_CYCLES_P(PWRT_CYCLES_P)) u_data_eeprom_write_guard_asserts (
    .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CODE_PROTECT(CODE_PROTECT),
    .EXT_REQ(EXT_REQ), .EXT_WRITE(EXT_WRITE), .EXT_RDATA(EXT_RDATA),
    .EXT_ACK(EXT_ACK), .EXT_REFUSED(EXT_REFUSED));

/* File: tb/data_eeprom_write_guard_test.sv */
`timescale 1ns/100ps
module data_eeprom_write_guard_test
    import eeprom_guard_pkg::*;
;
    localparam int PW = 40;
    localparam int WC = 5;
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic CODE_PROTECT = 1'b0;
    logic WRITE_PROTECT = 1'b0;
    logic EXT_REQ = 1'b0;
    logic EXT_WRITE = 1'b0;
    logic [7:0] EXT_ADDR = 8'h00;
    logic [7:0] EXT_WDATA = 8'h00;
    logic [7:0] EXT_RDATA;
    logic EXT_ACK;
    logic EXT_REFUSED;
    logic IRQ;
    int bad_count = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic err;
    data_eeprom_write_guard #(.PWRT_CYCLES_P(PW), .WRITE_CYCLES_P(WC))
        u_data_eeprom_write_guard (
        .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .CODE_PROTECT(CODE_PROTECT),
        .WRITE_PROTECT(WRITE_PROTECT), .EXT_REQ(EXT_REQ),
        .EXT_WRITE(EXT_WRITE), .EXT_ADDR(EXT_ADDR), .EXT_WDATA(EXT_WDATA),
        .EXT_RDATA(EXT_RDATA), .EXT_ACK(EXT_ACK),
        .EXT_REFUSED(EXT_REFUSED), .IRQ(IRQ));
    always #4 CLOCK = ~CLOCK;
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do
        begin
            @(posedge CLOCK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic ext(input logic w, input logic [7:0] a, d, input logic rf);
        @(posedge CLOCK);
        EXT_REQ <= 1'b1;
        EXT_WRITE <= w;
        EXT_ADDR <= a;
        EXT_WDATA <= d;
        @(posedge CLOCK);
        EXT_REQ <= 1'b0;
        @(posedge CLOCK);
        chk("ext_ack", 32'h1, {31'h0, EXT_ACK});
        chk("ext_refused", {31'h0, rf}, {31'h0, EXT_REFUSED});
    endtask
    // Unlock then start; permit set in the same word
    task automatic start_wr(input logic [7:0] a, d);
        apb(1'b1, OFS_ADDR_LOW, {24'h0, a});
        apb(1'b1, OFS_DATA, {24'h0, d});
        apb(1'b1, OFS_UNLOCK, 32'h55);
        apb(1'b1, OFS_UNLOCK, 32'haa);
        apb(1'b1, OFS_CONTROL, 32'h06);
    endtask
    task automatic rd_byte(input logic [7:0] a, e);
        apb(1'b1, OFS_CONTROL, 32'h00);
        apb(1'b1, OFS_ADDR_LOW, {24'h0, a});
        apb(1'b1, OFS_CONTROL, 32'h01);
        apb(1'b0, OFS_DATA, 32'h0);
        chk("read_back", {24'h0, e}, rd);
    endtask
    task automatic t_powerup;
        apb(1'b0, OFS_CONTROL, 32'h0);
        chk("ctl_reset", 32'h0, rd);
        ext(1'b1, 8'h21, 8'h99, 1'b1);
        apb(1'b1, OFS_UNLOCK, 32'h55);
        apb(1'b1, OFS_UNLOCK, 32'haa);
        apb(1'b1, OFS_CONTROL, 32'h06);
        apb(1'b0, OFS_CONTROL, 32'h0);
        chk("ctl_pwrt", 32'h0, rd & 32'h0a);
        apb(1'b0, OFS_STATE, 32'h0);
        chk("pwrt_flag", 32'h0, rd & 32'h02);
        repeat (PW) @(posedge CLOCK);
    endtask
    task automatic t_write;
        int n;
        start_wr(8'h21, 8'h5a);
        apb(1'b0, OFS_CONTROL, 32'h0);
        chk("start_set", 32'h2, rd & 32'h2);
        n = 0;
        while (rd[CTL_START] !== 1'b0 && n < 30)
        begin
            apb(1'b0, OFS_CONTROL, 32'h0);
            n++;
        end
        chk("start_clear", 32'h0, rd & 32'h0a);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk("irq_done", 32'h1, rd);
        chk("irq_masked", 32'h0, {31'h0, IRQ});
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        // Interrupt flop updates on the edge that ends the mask write
        @(posedge CLOCK);
        chk("irq_on", 32'h1, {31'h0, IRQ});
        apb(1'b1, OFS_IRQ_STATUS, 32'h1);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk("irq_off", 32'h0, {31'h0, IRQ});
        rd_byte(8'h21, 8'h5a);
    endtask
    task automatic t_guard;
        // Without unlock the start is dropped silently
        apb(1'b1, OFS_CONTROL, 32'h06);
        apb(1'b0, OFS_CONTROL, 32'h0);
        chk("no_unlock", 32'h0, rd & 32'h0a);
        // Unlocked but permit cleared in the start word
        apb(1'b1, OFS_UNLOCK, 32'h55);
        apb(1'b1, OFS_UNLOCK, 32'haa);
        apb(1'b1, OFS_CONTROL, 32'h02);
        apb(1'b0, OFS_CONTROL, 32'h0);
        chk("no_permit", 32'h0, rd & 32'h0e);
        for (int i = 0; i < 2; i++)
        begin
            WRITE_PROTECT <= (i == 0);
            apb(1'b1, OFS_ADDR_HIGH, {31'h0, i[0]});
            start_wr(8'h21, 8'h33);
            apb(1'b0, OFS_CONTROL, 32'h0);
            chk("fault", 32'h08, rd & 32'h0a);
            WRITE_PROTECT <= 1'b0;
            apb(1'b1, OFS_ADDR_HIGH, 32'h0);
            apb(1'b1, OFS_IRQ_STATUS, 32'h3);
        end
        repeat (WC + 4) @(posedge CLOCK);
        rd_byte(8'h21, 8'h5a);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
    endtask
    task automatic t_ext;
        CODE_PROTECT <= 1'b1;
        ext(1'b0, 8'h21, 8'h00, 1'b1);
        ext(1'b1, 8'h21, 8'h77, 1'b1);
        CODE_PROTECT <= 1'b0;
        ext(1'b0, 8'h21, 8'h00, 1'b0);
        chk("ext_rdata", 32'h5a, {24'h0, EXT_RDATA});
        // Accepted write, then one refused while the cells are busy
        ext(1'b1, 8'h22, 8'h77, 1'b0);
        ext(1'b1, 8'h23, 8'h11, 1'b1);
        repeat (WC + 4) @(posedge CLOCK);
        rd_byte(8'h22, 8'h77);
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge CLOCK);
        RST <= 1'b0;
        t_powerup();
        t_write();
        t_guard();
        t_ext();
        wrap_up();
    end
    initial
    begin
        #(8 * 20000);
        bad_count++;
        wrap_up();
    end
endmodule
